// ===== core/gpfm_regs.svh
// Register indices, field positions and reset values of the pin mux
`ifndef GPFM_REGS_SVH
`define GPFM_REGS_SVH
`define GPFM_IDX_PIN0 6'h0B
`define GPFM_IDX_PIN1 6'h0C
`define GPFM_IDX_IOPORT 6'h0E
`define GPFM_SEL_MSB 4
`define GPFM_PUP_BIT 5
`define GPFM_DRV_MSB 7
`define GPFM_DRV_LSB 6
`define GPFM_STS_LSB 4
`define GPFM_CFG_RST 8'h00
`define GPFM_DIO_RST 2'h0
`endif

// ===== core/gpfm_pkg.sv
// Types shared by the general pin function mux
package gpfm_pkg;
    typedef enum logic [4:0] {
        FN_POR_N   = 5'h00,
        FN_WAKEUP  = 5'h01,
        FN_LOWBAT  = 5'h02,
        FN_DIN     = 5'h03,
        FN_EXT_FALL = 5'h04,
        FN_EXT_RISE = 5'h05,
        FN_EXT_ANY = 5'h06,
        FN_ADC     = 5'h07,
        FN_TST_AN  = 5'h08,
        FN_TST_AP  = 5'h09,
        FN_DOUT    = 5'h0A,
        FN_TST_DO  = 5'h0B,
        FN_TST_ON  = 5'h0C,
        FN_TST_OP  = 5'h0D,
        FN_VREF    = 5'h0E,
        FN_TXCLK   = 5'h0F,
        FN_TXDATA  = 5'h10,
        FN_RETX    = 5'h11,
        FN_TXSTATE = 5'h12,
        FN_FIFO_AF = 5'h13,
        FN_VDD     = 5'h1D
    } gpfm_func_t;
endpackage

// ===== core/gpfm_top.sv
// Function mux, configuration registers and APB slave for two pins
// Operation
// - Config low five bits pick what the pin drives or samples.
// - Code 00000 drives the inverted power-on reset out.
// - Code 00001 drives high once the wake-up timer expired.
// - Code 00010 drives high while supply is below threshold.
// - Code 00011 makes the pin a sampled digital input.
// - Codes 00100-00110 catch falling, rising or any edge.
// - Code 00111 routes the pin to the converter, driver off.
// - Code 01010 drives the pin from a software bit.
// - Code 01110 puts the reference voltage on the pin.
// - Code 01111 drives the transmit data clock out.
// - Code 10000 takes modulation data from the pin.
// - Code 10001 takes a retransmission request from the pin.
// - Code 10010 shows the transmit state.
// - Code 10011 shows the FIFO almost-full flag.
// - Bit 5 enables pull-up, only while the pin is an input.
// - Bits 7:6 set the drive strength.
// - Each pin has its own pull-up enable in its register.
// - Direct I/O bit sets output level or reads input level.
// - Edge events set a readable per-pin status bit.
`timescale 1ns/1ns
`include "gpfm_regs.svh"
module gpfm_top (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core status, same clock
    input wire logic por_active,
    input wire logic wakeup_expired,
    input wire logic low_batt,
    input wire logic tx_state,
    input wire logic fifo_almost_full,
    input wire logic tx_data_clk,
    // Core event outputs
    output logic tx_mod_data,
    output logic tx_mod_data_sel,
    output logic retx_request,
    output logic [1:0] ext_int_event,
    // Pins, index 0 and 1
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [1:0] adc_route,
    output logic [1:0] vref_route,
    output logic pin0_pullup_enable,
    output logic pin1_pullup_enable,
    output logic [1:0] pin0_drive_strength,
    output logic [1:0] pin1_drive_strength
);
    logic [7:0] cfg_r [2];
    logic [1:0] dio_r;
    logic [1:0] ists_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [1:0] out_r;
    logic [1:0] oe_r;
    logic [1:0] adc_r;
    logic [1:0] vref_r;
    logic [1:0] pup_r;
    logic [1:0] drv0_r;
    logic [1:0] drv1_r;
    logic [1:0] evt_r;
    logic txd_r;
    logic txd_sel_r;
    logic retx_r;
    logic [31:0] rdata_r;
    logic ready_r;
    logic err_r;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] hit;
    logic [1:0] rdback;
    logic [4:0] sel [2];
    logic setup;
    logic wr_acc;
    logic mapped;

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [5:0] idx);
        return (a[1:0] == 2'h0) && (a[7:2] == idx);
    endfunction

    // Digital input codes; pull-up only counts for these
    function automatic logic is_din(input logic [4:0] s);
        return s inside {gpfm_pkg::FN_DIN, gpfm_pkg::FN_EXT_FALL,
                         gpfm_pkg::FN_EXT_RISE, gpfm_pkg::FN_EXT_ANY,
                         gpfm_pkg::FN_TXDATA, gpfm_pkg::FN_RETX};
    endfunction

    // Returns {drive enable, level}
    function automatic logic [1:0] drive(input logic [4:0] s,
                                         input logic dio);
        logic [1:0] r;
        r = 2'h0;
        unique case (s) inside
            gpfm_pkg::FN_POR_N: r = {1'b1, !por_active};
            gpfm_pkg::FN_WAKEUP: r = {1'b1, wakeup_expired};
            gpfm_pkg::FN_LOWBAT: r = {1'b1, low_batt};
            gpfm_pkg::FN_DOUT: r = {1'b1, dio};
            gpfm_pkg::FN_TXCLK: r = {1'b1, tx_data_clk};
            gpfm_pkg::FN_TXSTATE: r = {1'b1, tx_state};
            gpfm_pkg::FN_FIFO_AF: r = {1'b1, fifo_almost_full};
            gpfm_pkg::FN_VDD: r = 2'h3;
            // Test codes: driver held off, nothing leaks out
            [5'h08:5'h09]: r = 2'h0;
            [5'h0B:5'h0D]: r = 2'h0;
            // Ranges skip the VDD code so no two items overlap
            [5'h14:5'h1C]: r = 2'h2;
            [5'h1E:5'h1F]: r = 2'h2;
            // Inputs, converter and reference leave the driver off
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    assign sel[0] = cfg_r[0][`GPFM_SEL_MSB:0];
    assign sel[1] = cfg_r[1][`GPFM_SEL_MSB:0];
    assign rise = sync2_r & ~sync3_r;
    assign fall = ~sync2_r & sync3_r;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && ready_r && pwrite;
    assign mapped = addr_is(paddr, `GPFM_IDX_PIN0) ||
                    addr_is(paddr, `GPFM_IDX_PIN1) ||
                    addr_is(paddr, `GPFM_IDX_IOPORT);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            hit[i] = (sel[i] == gpfm_pkg::FN_EXT_FALL && fall[i]) ||
                     (sel[i] == gpfm_pkg::FN_EXT_RISE && rise[i]) ||
                     (sel[i] == gpfm_pkg::FN_EXT_ANY &&
                      (rise[i] || fall[i]));
            // Direct input reads the pin, else the stored bit
            rdback[i] = (sel[i] == gpfm_pkg::FN_DIN) ?
                        sync2_r[i] : dio_r[i];
        end
    end

    // Pin synchronisers; only stage two onward is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            sync3_r <= 2'h0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Configuration registers, one per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r[0] <= `GPFM_CFG_RST;
            cfg_r[1] <= `GPFM_CFG_RST;
        end else if (wr_acc) begin
            if (addr_is(paddr, `GPFM_IDX_PIN0)) begin
                cfg_r[0] <= pwdata[7:0];
            end
            if (addr_is(paddr, `GPFM_IDX_PIN1)) begin
                cfg_r[1] <= pwdata[7:0];
            end
        end
    end

    // Direct I/O bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dio_r <= `GPFM_DIO_RST;
        end else if (wr_acc && addr_is(paddr, `GPFM_IDX_IOPORT)) begin
            dio_r <= pwdata[1:0];
        end
    end

    // Edge status: write one clears, a new edge wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= 2'h0;
            evt_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hit[i]) begin
                    ists_r[i] <= 1'b1;
                end else if (wr_acc &&
                             addr_is(paddr, `GPFM_IDX_IOPORT) &&
                             pwdata[`GPFM_STS_LSB + i]) begin
                    ists_r[i] <= 1'b0;
                end
            end
            evt_r <= hit;
        end
    end

    // Pin drivers and analog routing, one cycle behind the code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r <= 2'h0;
            oe_r <= 2'h0;
            adc_r <= 2'h0;
            vref_r <= 2'h0;
            pup_r <= 2'h0;
            drv0_r <= 2'h0;
            drv1_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                {oe_r[i], out_r[i]} <= drive(sel[i], dio_r[i]);
                adc_r[i] <= sel[i] == gpfm_pkg::FN_ADC;
                vref_r[i] <= sel[i] == gpfm_pkg::FN_VREF;
                pup_r[i] <= cfg_r[i][`GPFM_PUP_BIT] &&
                            is_din(sel[i]);
            end
            drv0_r <= cfg_r[0][`GPFM_DRV_MSB:`GPFM_DRV_LSB];
            drv1_r <= cfg_r[1][`GPFM_DRV_MSB:`GPFM_DRV_LSB];
        end
    end

    // Modulation data, pin 0 has priority; retransmission from either pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_r <= 1'b0;
            txd_sel_r <= 1'b0;
            retx_r <= 1'b0;
        end else begin
            if (sel[0] == gpfm_pkg::FN_TXDATA) begin
                txd_r <= sync2_r[0];
                txd_sel_r <= 1'b1;
            end else if (sel[1] == gpfm_pkg::FN_TXDATA) begin
                txd_r <= sync2_r[1];
                txd_sel_r <= 1'b1;
            end else begin
                txd_r <= 1'b0;
                txd_sel_r <= 1'b0;
            end
            retx_r <= (sel[0] == gpfm_pkg::FN_RETX && rise[0]) ||
                      (sel[1] == gpfm_pkg::FN_RETX && rise[1]);
        end
    end

    // APB: data latched in setup, answered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ready_r <= setup;
            err_r <= setup && !mapped;
            if (setup) begin
                rdata_r <= 32'h0;
                if (addr_is(paddr, `GPFM_IDX_PIN0)) begin
                    rdata_r[7:0] <= cfg_r[0];
                end else if (addr_is(paddr, `GPFM_IDX_PIN1)) begin
                    rdata_r[7:0] <= cfg_r[1];
                end else if (addr_is(paddr, `GPFM_IDX_IOPORT)) begin
                    rdata_r[5:4] <= ists_r;
                    rdata_r[1:0] <= rdback;
                end
            end
        end
    end

    assign prdata = rdata_r;
    assign pready = ready_r;
    assign pslverr = err_r;
    assign pin_out = out_r;
    assign pin_oe = oe_r;
    assign adc_route = adc_r;
    assign vref_route = vref_r;
    assign pin0_pullup_enable = pup_r[0];
    assign pin1_pullup_enable = pup_r[1];
    assign pin0_drive_strength = drv0_r;
    assign pin1_drive_strength = drv1_r;
    assign tx_mod_data = txd_r;
    assign tx_mod_data_sel = txd_sel_r;
    assign retx_request = retx_r;
    assign ext_int_event = evt_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_por;
        sel[0] == gpfm_pkg::FN_POR_N |=>
            pin_out[0] == !$past(por_active) && pin_oe[0];
    endproperty
    a_por: assert property (p_por)
        else $error("pin0 not inverted reset");

    property p_status;
        sel[1] == gpfm_pkg::FN_WAKEUP |=>
            pin_out[1] == $past(wakeup_expired) && pin_oe[1];
    endproperty
    a_status: assert property (p_status)
        else $error("pin1 not wake-up state");

    property p_lowbat;
        sel[0] == gpfm_pkg::FN_LOWBAT |=> pin_out[0] == $past(low_batt);
    endproperty
    a_lowbat: assert property (p_lowbat)
        else $error("pin0 not low battery");

    property p_dout;
        sel[0] == gpfm_pkg::FN_DOUT |=>
            pin_oe[0] && pin_out[0] == $past(dio_r[0]);
    endproperty
    a_dout: assert property (p_dout)
        else $error("direct output level wrong");

    property p_inputs;
        is_din(sel[1]) || sel[1] == gpfm_pkg::FN_ADC |=> !pin_oe[1];
    endproperty
    a_inputs: assert property (p_inputs)
        else $error("input pin driven");

    property p_adc;
        sel[0] == gpfm_pkg::FN_ADC |=> adc_route[0] && !pin_oe[0];
    endproperty
    a_adc: assert property (p_adc)
        else $error("converter route missing");

    property p_fall;
        sel[0] == gpfm_pkg::FN_EXT_FALL && $fell(sync2_r[0]) ##1
            sel[0] == gpfm_pkg::FN_EXT_FALL |-> ists_r[0] && evt_r[0];
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling edge not caught");

    property p_sticky;
        ists_r[1] && !wr_acc |=> ists_r[1];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status lost without clear");

    property p_pullup;
        !is_din(sel[0]) |=> !pin0_pullup_enable;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up on non-input");

    property p_reserved;
        sel[1] >= 5'h14 |=> pin_oe[1] &&
            pin_out[1] == ($past(sel[1]) == gpfm_pkg::FN_VDD);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code level wrong");

    property p_txclk;
        sel[1] == gpfm_pkg::FN_TXCLK |=> pin_out[1] == $past(tx_data_clk);
    endproperty
    a_txclk: assert property (p_txclk)
        else $error("tx clock not on pin");

    property p_retx;
        sel[0] == gpfm_pkg::FN_RETX && rise[0] |=> retx_request;
    endproperty
    a_retx: assert property (p_retx)
        else $error("retransmission pulse missing");

    property p_txdata;
        sel[0] == gpfm_pkg::FN_TXDATA |=>
            tx_mod_data_sel && tx_mod_data == $past(sync2_r[0]);
    endproperty
    a_txdata: assert property (p_txdata)
        else $error("modulation data not from pin0");

    c_write: cover property (wr_acc ##1 !pready);
    c_edge: cover property (evt_r[1] ##[1:20] ists_r[1] && wr_acc);
    c_retx: cover property (retx_request);
    c_err: cover property (pready && pslverr);
endmodule // gpfm_top

// ===== bench/gpfm_pin_model.sv
// Host-side logic model that drives or releases the two pins
`timescale 1ns/1ns
module gpfm_pin_model (
    // Clock
    input wire logic pclk,
    // Pads from the device
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic pin0_pullup_enable,
    input wire logic pin1_pullup_enable,
    // Host drive requests
    input wire logic [1:0] host_en,
    input wire logic [1:0] host_val,
    // Resolved wire level
    output logic [1:0] pin_in
);
    logic [1:0] last_r = 2'h0;
    logic [1:0] pu;
    assign pu = {pin1_pullup_enable, pin0_pullup_enable};
    // Host supplies modulation bits and input levels
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            if (pin_oe[p])
                pin_in[p] = pin_out[p];
            else if (host_en[p])
                pin_in[p] = host_val[p];
            else if (pu[p])
                pin_in[p] = 1'b1;
            else
                pin_in[p] = ~last_r[p];
        end
    end
    // Floating line keeps toggling, so no stale level is read
    always_ff @(posedge pclk) begin
        last_r <= pin_in;
    end
endmodule // gpfm_pin_model

// ===== bench/general_pin_function_mux_tb.sv
// Random and corner-case bench for the two-pin function mux
`timescale 1ns/1ns
module general_pin_function_mux_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, tx_mod_data, tx_mod_data_sel, retx_request, err;
    logic [1:0] ext_int_event, pin_in, pin_out, pin_oe, adc_route, vref_route;
    logic pin0_pullup_enable, pin1_pullup_enable;
    logic [1:0] pin0_drive_strength, pin1_drive_strength, e;
    logic [5:0] core = 6'h00;
    logic [1:0] host_en = 2'h0;
    logic [1:0] host_val = 2'h0;
    logic [31:0] rs = 32'h91FBD37A;
    logic [4:0] c;
    logic [4:0] oc [10] = '{5'h00, 5'h01, 5'h02, 5'h0A, 5'h0F, 5'h12,
        5'h13, 5'h1D, 5'h14, 5'h1F};
    // Test codes 08,09,0B..0D never programmed
    logic [4:0] ic [8] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0E,
        5'h10, 5'h11};
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int ev_cnt = 0;
    int rx_cnt = 0;
    int ep = 0;
    always #50 pclk = ~pclk;
    gpfm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_active(core[5]), .wakeup_expired(core[4]), .low_batt(core[3]),
        .tx_state(core[2]), .fifo_almost_full(core[1]),
        .tx_data_clk(core[0]), .tx_mod_data(tx_mod_data),
        .tx_mod_data_sel(tx_mod_data_sel), .retx_request(retx_request),
        .ext_int_event(ext_int_event), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .adc_route(adc_route), .vref_route(vref_route),
        .pin0_pullup_enable(pin0_pullup_enable),
        .pin1_pullup_enable(pin1_pullup_enable),
        .pin0_drive_strength(pin0_drive_strength),
        .pin1_drive_strength(pin1_drive_strength));
    gpfm_pin_model host_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin0_pullup_enable(pin0_pullup_enable),
        .pin1_pullup_enable(pin1_pullup_enable), .host_en(host_en),
        .host_val(host_val), .pin_in(pin_in));
    task test_done();
        $display("counts: comparisons=%0d failures=%0d", comparisons,
            failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        ev_cnt += int'(ext_int_event[ep] === 1'b1);
        rx_cnt += int'(retx_request === 1'b1);
        if (cycles == 30000) begin
            failures++;
            test_done();
        end
    end
    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // Expected {drive enable, level} for an output code
    function logic [1:0] exp_pin(input logic [4:0] k, input logic [5:0] cr,
        input logic dio);
        case (k)
            5'h00: return {1'b1, ~cr[5]};
            5'h01: return {1'b1, cr[4]};
            5'h02: return {1'b1, cr[3]};
            5'h0A: return {1'b1, dio};
            5'h0F: return {1'b1, cr[0]};
            5'h12: return {1'b1, cr[2]};
            5'h13: return {1'b1, cr[1]};
            5'h1D: return 2'h3;
            default: return 2'h2;
        endcase
    endfunction
    function logic din(input logic [4:0] k);
        return k inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t %s: %h vs %h", $time, msg, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cfg(input int p, input logic [7:0] d);
        apb(1'b1, p ? 8'h30 : 8'h2C, {24'h000000, d});
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(pin_oe, 2'h3, "reset drive");
        check(pin_out, 2'h3, "reset level");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            v[3] = v[3] & v[4]; // Keeps clear of test codes
            cfg(i % 2, v[7:0]);
            apb(1'b0, (i % 2) ? 8'h30 : 8'h2C, 32'h00000000);
            check(rd, {24'h000000, v[7:0]}, "cfg readback");
            check((i % 2) ? pin1_drive_strength : pin0_drive_strength,
                v[7:6], "drive");
        end
        apb(1'b1, 8'h34, 32'h000000FF);
        check(err, 1'b1, "unmapped write");
        apb(1'b0, 8'h2D, 32'h00000000);
        check(err, 1'b1, "misaligned read");
        check(rd, 32'h00000000, "misaligned data");
        apb(1'b0, 8'h30, 32'h00000000);
        check(rd, {24'h000000, v[7:0]}, "cfg kept");
        $display("test registers done");
        for (int j = 0; j < 10; j++) for (int p = 0; p < 2; p++) begin
            v = rnd();
            c = oc[j];
            core <= v[13:8];
            cfg(p, {v[7:5], c});
            apb(1'b1, 8'h38, {30'h00000000, v[17:16]});
            for (int k = 0; k < 2; k++) begin
                repeat (3) @(posedge pclk);
                e = exp_pin(c, core, v[16 + p]);
                check(pin_oe[p], e[1], "out drive");
                check(pin_out[p], e[0],
                    "out level");
                check(p ? pin1_pullup_enable : pin0_pullup_enable, 1'b0,
                    "pullup on output");
                core <= ~core;
            end
        end
        $display("test output codes done");
        for (int j = 0; j < 8; j++) for (int p = 0; p < 2; p++) begin
            v = rnd();
            c = ic[j];
            cfg(p, {v[7:5], c});
            repeat (3) @(posedge pclk);
            check(pin_oe[p], 1'b0, "input drive");
            check(p ? pin1_pullup_enable : pin0_pullup_enable,
                v[5] & din(c), "pullup");
            check(adc_route[p], c == 5'h07, "adc");
            check(vref_route[p], c == 5'h0E, "vref");
        end
        for (int p = 0; p < 2; p++) begin
            v = rnd();
            cfg(p, 8'h03);
            host_en[p] <= 1'b1;
            host_val[p] <= v[0];
            repeat (4) @(posedge pclk);
            apb(1'b0, 8'h38, 32'h00000000);
            check(rd[p], v[0], "direct input");
            cfg(p, 8'h23);
            host_en[p] <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b0, 8'h38, 32'h00000000);
            check(rd[p], 1'b1, "pulled up input");
        end
        $display("test input codes done");
        for (int j = 1; j < 8; j++) for (int p = 0; p < 2; p++) begin
            c = ic[j];
            if (c inside {5'h04, 5'h05, 5'h06, 5'h11}) begin
                host_en[p] <= 1'b1;
                host_val[p] <= 1'b1;
                cfg(p, {3'h0, c});
                repeat (5) @(posedge pclk);
                apb(1'b1, 8'h38, 32'h00000030);
                ep = p;
                ev_cnt = 0;
                rx_cnt = 0;
                host_val[p] <= 1'b0;
                repeat (5) @(posedge pclk);
                host_val[p] <= 1'b1;
                repeat (5) @(posedge pclk);
                check(ev_cnt, c == 5'h06 ? 2 : (c == 5'h11 ? 0 : 1),
                    "edge events");
                check(rx_cnt, c == 5'h11, "retx pulses");
                apb(1'b0, 8'h38, 32'h00000000);
                check(rd[4 + p], c != 5'h11, "status set");
                apb(1'b1, 8'h38, 32'h00000030);
                apb(1'b0, 8'h38, 32'h00000000);
                check(rd[5:4], 2'h0, "status cleared");
            end
        end
        $display("test edge events done");
        v = rnd();
        cfg(0, 8'h10);
        cfg(1, 8'h10);
        host_en <= 2'h3;
        host_val <= v[1:0];
        repeat (4) @(posedge pclk);
        check(tx_mod_data_sel, 1'b1, "mod select");
        check(tx_mod_data, v[0], "mod data pin0");
        cfg(0, 8'h03);
        repeat (4) @(posedge pclk);
        check(tx_mod_data, v[1], "mod data pin1");
        cfg(1, 8'h03);
        repeat (4) @(posedge pclk);
        check(tx_mod_data_sel, 1'b0, "mod deselect");
        $display("test modulation done");
        test_done();
    end
endmodule // general_pin_function_mux_tb
